/* bench/power_mode_sva.sv */
// Assertion checker bound to the power mode controller ports.
`timescale 1ns/1ns
module power_mode_sva #(
  parameter int WAKE_PINS = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_sleep_req,
  input wire logic [WAKE_PINS-1:0] i_wake_pin,
  input wire logic i_timer_wake,
  input wire logic o_flash_power_off,
  input wire logic o_core_asleep,
  input wire logic o_cpu_reset,
  input wire logic o_sys_reset,
  input wire logic o_shutdown,
  input wire logic [15:0] o_pull_a,
  input wire logic [15:0] o_pull_c,
  input wire logic [15:0] o_pull_d,
  input wire logic [15:0] o_pull_e
);
  // ==========
  // Control write tracking.
  // ==========
  logic ctl_dp, next_ctl_dp; // Control write in its data phase.
  logic flash_q, next_flash_q; // Flash bit of the last control write.
  always_comb begin
    next_ctl_dp = i_hsel && i_htrans[1] && i_hready && i_hwrite && i_haddr[7:0] == 8'h00;
    next_flash_q = ctl_dp ? i_hwdata[8] : flash_q;
  end
  always_ff @(posedge i_ref_clk) begin
    ctl_dp <= next_ctl_dp && !i_sys_rst;
    flash_q <= next_flash_q;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // ==========
  // Properties.
  // ==========
  chk_key_reject: assert property (ctl_dp && i_hwdata[31:16] != 16'h5A3C
    |=> $stable(o_flash_power_off) [*2]) else $error("Flash bit moved on a bad key.");
  chk_flash_now: assert property (ctl_dp && i_hwdata[31:16] == 16'h5A3C
    |=> ##[0:1] o_flash_power_off == flash_q) else $error("Flash bit not applied.");
  chk_cpu_pulse: assert property ($rose(o_cpu_reset)
    |-> o_cpu_reset [*4] ##1 !o_cpu_reset) else $error("CPU reset pulse length wrong.");
  chk_sys_pulse: assert property ($rose(o_sys_reset)
    |-> o_sys_reset [*4] ##1 !o_sys_reset) else $error("System reset pulse length wrong.");
  chk_pull_idle: assert property (!o_shutdown
    |-> (o_pull_a | o_pull_c | o_pull_d | o_pull_e) == 16'h0000) else $error("Pull outside shutdown.");
  chk_shut_hold: assert property (o_shutdown && !i_timer_wake && !(|i_wake_pin)
    |=> o_shutdown) else $error("Shutdown left.");
  chk_shut_asleep: assert property (o_shutdown |-> o_core_asleep)
    else $error("Shutdown while awake.");
  chk_run_stays: assert property (!o_core_asleep && !i_sleep_req |=> !o_core_asleep)
    else $error("Sleep without request.");
  chk_resets_apart: assert property (!(o_cpu_reset && o_sys_reset))
    else $error("Both resets at once.");
endmodule // power_mode_sva
bind power_mode_controller power_mode_sva #(.WAKE_PINS(WAKE_PINS)) u_chk (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .i_sleep_req(i_sleep_req), .i_wake_pin(i_wake_pin), .i_timer_wake(i_timer_wake),
  .o_flash_power_off(o_flash_power_off), .o_core_asleep(o_core_asleep),
  .o_cpu_reset(o_cpu_reset), .o_sys_reset(o_sys_reset), .o_shutdown(o_shutdown),
  .o_pull_a(o_pull_a), .o_pull_c(o_pull_c), .o_pull_d(o_pull_d), .o_pull_e(o_pull_e));

/* bench/test_power_mode_controller.sv */
// Self-checking testbench for the power mode controller.
`timescale 1ns/1ns
module test_power_mode_controller;
  // ==========
  // Signals.
  // ==========
  localparam int SHUT_CYC = 40; // Short shutdown wake delay.
  localparam logic [15:0] KEY = power_mode_pkg::UNLOCK_KEY; // Unlock key.
  localparam logic [7:0] POFS [4] = '{8'h10, 8'h18, 8'h1C, 8'h20}; // Pull offsets.
  localparam logic [31:0] PMSK [4] = '{power_mode_pkg::MASK_PULL_A,
    power_mode_pkg::MASK_PULL_C, power_mode_pkg::MASK_PULL_D, power_mode_pkg::MASK_PULL_E};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, sleep_req = 1'b0;
  logic go = 1'b0; // Starts a partner wake event.
  logic [1:0] htrans = 2'h0, which = 2'h0;
  logic [3:0] delay = 4'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, flash_off, asleep, cpu_rst, sys_rst, shut, timer_wake, irq, boot;
  logic [1:0] wake_pin;
  wire [3:0][15:0] pull;
  logic [31:0] bk [8];
  logic [31:0] pv [4];
  int miscompares = 0, n_tests = 0, d = 0;
  always #20 clk = ~clk;
  power_mode_controller #(.SHUT_WAKE_CYCLES(SHUT_CYC), .WAKE_PINS(2)) i_dut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
    .i_sleep_req(sleep_req), .i_wake_pin(wake_pin), .i_timer_wake(timer_wake),
    .i_periph_irq(irq), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .o_flash_power_off(flash_off), .o_core_asleep(asleep), .o_cpu_reset(cpu_rst),
    .o_sys_reset(sys_rst), .o_shutdown(shut), .o_pull_a(pull[0]), .o_pull_c(pull[1]),
    .o_pull_d(pull[2]), .o_pull_e(pull[3]));
  wake_partner i_partner (.i_ref_clk(clk), .i_fire(go), .i_which(which), .i_delay(delay),
    .o_wake_pin(wake_pin), .o_timer_wake(timer_wake), .o_periph_irq(irq),
    .o_boot_select(boot));
  // ==========
  // Tasks.
  // ==========
  task automatic chk(input logic [31:0] got, exp, input string w);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask
  // One AHB-Lite word transfer; read data lands in rd.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    logic ok;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin
      @(negedge clk);
      ok = hreadyout;
      @(posedge clk);
    end while (ok !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge clk);
      ok = hreadyout;
      rd = hrdata;
      @(posedge clk);
    end while (ok !== 1'b1);
    @(negedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e, input string w);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e, w);
  endtask
  // Control write with the reserved low byte kept at zero.
  task automatic wctl(input logic [15:0] k, input logic [1:0] s, we, input logic fl);
    bus(1'b1, 8'h00, {k, s, 3'h0, we, fl, 8'h00});
  endtask
  task automatic nap();
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    @(negedge clk);
  endtask
  // Asks the partner for one wake event after a random delay.
  task automatic fire(input logic [1:0] w);
    d = $urandom_range(0, 15);
    @(posedge clk);
    which <= w;
    delay <= 4'(d);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // Waits for resume (0), CPU reset (1) or system reset (2) within lim + d + 4 cycles.
  task automatic await(input int k, input int lim, input string w);
    int n = 0;
    while (n < lim + 40 && (k == 0 ? asleep : (k == 1 ? !cpu_rst : !sys_rst)) !== 1'b0) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, n <= lim + d + 4}, 32'h1, w);
  endtask
  function automatic logic [31:0] rnd_pull(input logic [31:0] m);
    logic [31:0] v;
    for (int j = 0; j < 16; j++) v[2*j +: 2] = 2'($urandom_range(0, 2));
    return v & m;
  endfunction
  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // Tests.
  // ==========
  initial begin
    #(40 * 20000);
    miscompares++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    d = $urandom(29009);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'h00, '1, 32'h0, "control reset");
    rdchk(8'h08, '1, 32'h0, "status reset");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wctl(KEY ^ 16'($urandom_range(1, 65535)), 2'h2, 2'h3, 1'b1);
      @(negedge clk);
      chk({29'h0, hreadyout, hresp, flash_off}, 32'h4, "bad key flash");
      rdchk(8'h00, 32'h0000C700, 32'h0, "bad key control");
    end
    wctl(KEY, 2'h0, 2'h0, 1'b1);
    @(negedge clk);
    chk({31'h0, flash_off}, 32'h1, "flash off");
    rdchk(8'h00, 32'h0000C700, 32'h100, "flash bit");
    wctl(KEY, 2'h0, 2'h0, 1'b0); // Flash power is toggled from SRAM code
    repeat (50) @(negedge clk); // Two microseconds before any flash fetch
    chk({31'h0, flash_off}, 32'h0, "flash on");
    $display("test key done");
    for (int i = 0; i < 4; i++) begin
      pv[i] = rnd_pull(PMSK[i]);
      rdchk(POFS[i], '1, 32'h0, "pull reset");
      bus(1'b1, POFS[i], pv[i]);
      rdchk(POFS[i], '1, pv[i], "pull value");
    end
    for (int i = 0; i < 8; i++) begin
      bk[i] = $urandom;
      bus(1'b1, 8'h40 + 8'(4 * i), bk[i]);
    end
    bus(1'b1, 8'h30, $urandom);
    for (int i = 0; i < 8; i++) rdchk(8'h40 + 8'(4 * i), '1, bk[i], "backup");
    rdchk(8'h30, '1, 32'h0, "unmapped");
    $display("test registers done");
    wctl(KEY, 2'h1, 2'h0, 1'b0);
    nap();
    chk({31'h0, asleep}, 32'h0, "select 01 sleep");
    wctl(KEY, 2'h0, 2'h0, 1'b0);
    nap();
    chk({31'h0, asleep}, 32'h1, "mode 0 entry");
    fire(2'h3);
    await(0, power_mode_pkg::MODE0_WAKE_CYC, "mode 0 resume");
    rdchk(8'h08, '1, 32'h0, "mode 0 no flag");
    $display("test mode 0 done");
    wctl(KEY, 2'h2, 2'h1, 1'b0);
    nap();
    fire(2'h1);
    repeat (30) @(negedge clk);
    chk({31'h0, asleep}, 32'h1, "disabled pin");
    fire(2'h0);
    await(1, power_mode_pkg::MODE2_WAKE_CYC, "mode 2 reset");
    await(0, 300, "mode 2 resume");
    rdchk(8'h08, '1, 32'h4, "mode 2 flag");
    rdchk(8'h00, 32'h0000C700, 32'h200, "mode 2 select");
    rdchk(8'h40, '1, bk[0], "backup kept");
    bus(1'b1, 8'h08, 32'h4);
    rdchk(8'h08, '1, 32'h0, "mode 2 clear");
    $display("test mode 2 done");
    wctl(KEY, 2'h3, 2'h2, 1'b0);
    nap();
    @(negedge clk);
    chk({31'h0, shut}, 32'h1, "shutdown entry");
    for (int i = 0; i < 4; i++) chk({16'h0, pull[i]}, pv[i], "shutdown pull");
    fire(2'h3);
    repeat (30) @(negedge clk);
    chk({31'h0, shut}, 32'h1, "irq in shutdown");
    fire(2'h2);
    await(2, SHUT_CYC, "shutdown reset");
    chk({31'h0, boot}, 32'h1, "boot select");
    await(0, 300, "shutdown resume");
    rdchk(8'h08, '1, 32'h8, "shutdown flag");
    rdchk(8'h00, '1, 32'h0, "select cleared");
    bus(1'b1, 8'h08, 32'h8);
    rdchk(8'h08, '1, 32'h0, "shutdown clear");
    $display("test shutdown done");
    wctl(KEY, 2'h2, 2'h0, 1'b0);
    nap();
    fire(2'h3);
    await(0, power_mode_pkg::MODE2_WAKE_CYC, "mode 2 again");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'h08, '1, 32'h0, "status after reset");
    $display("test power-on done");
    final_report();
  end
endmodule // test_power_mode_controller

/* bench/wake_partner.sv */
// Model of the wake pins, the hundred Hz timer and peripheral interrupts.
`timescale 1ns/1ns
module wake_partner (
  input wire logic i_ref_clk, // Reference clock.
  input wire logic i_fire, // Starts one wake event.
  input wire logic [1:0] i_which, // 0 and 1 pins, 2 timer, 3 interrupt.
  input wire logic [3:0] i_delay, // Cycles to wait before the event.
  output logic [1:0] o_wake_pin, // Wake-up pins, high to wake.
  output logic o_timer_wake, // Timer event.
  output logic o_periph_irq, // Peripheral interrupt.
  output logic o_boot_select // Boot select pin level.
);
  int cnt = -1; // Delay countdown, idle when negative.
  int hold = 0; // Cycles left with the source high.
  // Count the delay down, then hold the chosen source high two cycles.
  always @(posedge i_ref_clk) begin
    cnt <= i_fire ? int'(i_delay) : ((cnt > 0) ? cnt - 1 : -1);
    hold <= (cnt == 0) ? 2 : ((hold > 0) ? hold - 1 : 0);
  end
  assign o_wake_pin = (hold > 0 && !i_which[1]) ? (2'h1 << i_which[0]) : 2'h0;
  assign o_timer_wake = hold > 0 && i_which == 2'h2;
  assign o_periph_irq = hold > 0 && i_which == 2'h3;
  // Held high so that a shutdown wake boots normally.
  assign o_boot_select = 1'b1;
endmodule // wake_partner

/* rtl/power_mode_controller.sv */
// Power mode controller with AHB-Lite register slave.
`timescale 1ns/1ns
module power_mode_controller #(
  parameter int SHUT_WAKE_CYCLES = power_mode_pkg::SHUT_WAKE_CYC,
  parameter int WAKE_PINS = power_mode_pkg::WAKE_PINS
) (
  input wire logic i_ref_clk, // Always-on reference clock.
  input wire logic i_sys_rst, // Power-on reset, synchronous.
  input wire logic i_hsel, // AHB slave select.
  input wire logic [31:0] i_haddr, // AHB address.
  input wire logic [1:0] i_htrans, // AHB transfer type.
  input wire logic i_hwrite, // AHB write flag.
  input wire logic [2:0] i_hsize, // AHB size.
  input wire logic [31:0] i_hwdata, // AHB write data.
  input wire logic i_hready, // AHB bus ready.
  input wire logic i_sleep_req, // Processor sleep request pulse.
  input wire logic [WAKE_PINS-1:0] i_wake_pin, // Wake-up pins, active high.
  input wire logic i_timer_wake, // Hundred Hz timer event.
  input wire logic i_periph_irq, // Any enabled peripheral interrupt.
  output logic [31:0] o_hrdata, // AHB read data.
  output logic o_hreadyout, // AHB ready out.
  output logic o_hresp, // AHB response, always OKAY.
  output logic o_flash_power_off, // Flash supply cut when high.
  output logic o_core_asleep, // Core clocks and power held off.
  output logic o_cpu_reset, // CPU reset pulse after mode 2 wake.
  output logic o_sys_reset, // System reset pulse after shutdown wake.
  output logic o_shutdown, // Shutdown active, pulls applied.
  output logic [15:0] o_pull_a, // Port A pull selection.
  output logic [15:0] o_pull_c, // Port C pull selection.
  output logic [15:0] o_pull_d, // Port D pull selection.
  output logic [15:0] o_pull_e // Port E pull selection.
);

  // ==========================================================================
  // Elaboration checks.
  // ==========================================================================
  if (WAKE_PINS != power_mode_pkg::WAKE_PINS) begin : g_bad_pins
    $error("Wake pin count must match the control layout.");
  end
  if (SHUT_WAKE_CYCLES <= power_mode_pkg::RESET_PULSE_CYC) begin : g_bad_cyc
    $error("Shutdown wake count must exceed the reset pulse.");
  end

  // ==========================================================================
  // Register state.
  // ==========================================================================
  logic [1:0] sel, next_sel; // Low-power selection.
  logic [WAKE_PINS-1:0] wake_en, next_wake_en; // Wake pin enables.
  logic flash_off, next_flash_off; // Flash power off.
  logic flag_mode2, next_flag_mode2; // Mode 2 wake reset flag.
  logic flag_shut, next_flag_shut; // Shutdown wake reset flag.
  logic [31:0] pull_a, next_pull_a; // Port A pulls.
  logic [31:0] pull_c, next_pull_c; // Port C pulls.
  logic [31:0] pull_d, next_pull_d; // Port D pulls.
  logic [31:0] pull_e, next_pull_e; // Port E pulls.
  logic [7:0] backup [power_mode_pkg::BACKUP_BYTES]; // Backup bytes.

  // AHB data-phase capture.
  logic wr_pend, next_wr_pend; // Write data phase pending.
  logic [7:0] wr_addr, next_wr_addr; // Latched write address.
  logic [31:0] next_rdata; // Next read data.

  // Power sequencer.
  power_mode_pkg::power_state_e state, next_state; // Power state.
  power_mode_pkg::power_state_e wake_from, next_wake_from; // Which sleep woke.
  logic [31:0] cnt, next_cnt; // Delay counter.

  // ==========================================================================
  // Bus decode.
  // ==========================================================================
  logic addr_phase; // Valid address phase this cycle.
  logic [7:0] ofs; // Low address byte.
  logic [31:0] rd_mux; // Read value of the addressed register.
  logic wake_evt; // Wake-up condition for the present state.
  logic [WAKE_PINS-1:0] pin_hit; // Enabled pins that are asserted.
  logic backup_hit; // Address falls in the backup window.
  logic [4:0] bk_word; // Backup word base index.
  logic next_shut; // Next state is shutdown.

  assign addr_phase = i_hsel & i_htrans[1] & i_hready;
  assign ofs = i_haddr[7:0];
  assign bk_word = {ofs[4:2], 2'h0};
  assign next_shut = (next_state == power_mode_pkg::ST_SHUT);
  assign backup_hit = (ofs >= power_mode_pkg::OFS_BACKUP_LO) &&
                      (ofs <= power_mode_pkg::OFS_BACKUP_HI);

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_mux = 32'h0;
    if (backup_hit) begin
      rd_mux = {backup[bk_word + 5'h3], backup[bk_word + 5'h2],
                backup[bk_word + 5'h1], backup[bk_word]};
    end else begin
      case (ofs)
        power_mode_pkg::OFS_CONTROL: begin
          rd_mux[power_mode_pkg::SEL_LSB +: 2] = sel;
          rd_mux[power_mode_pkg::WAKE_EN_LSB +: WAKE_PINS] = wake_en;
          rd_mux[power_mode_pkg::FLASH_OFF_BIT] = flash_off;
        end
        power_mode_pkg::OFS_STATUS: begin
          rd_mux[power_mode_pkg::ST_MODE2_BIT] = flag_mode2;
          rd_mux[power_mode_pkg::ST_SHUT_BIT] = flag_shut;
        end
        power_mode_pkg::OFS_PULL_A: rd_mux = pull_a;
        power_mode_pkg::OFS_PULL_C: rd_mux = pull_c;
        power_mode_pkg::OFS_PULL_D: rd_mux = pull_d;
        power_mode_pkg::OFS_PULL_E: rd_mux = pull_e;
        default: rd_mux = 32'h0;
      endcase
    end
  end

  // Wake sources differ per sleep state.
  always_comb begin
    pin_hit = i_wake_pin & wake_en;
    case (state)
      power_mode_pkg::ST_SLEEP0: wake_evt = i_periph_irq;
      power_mode_pkg::ST_SLEEP2: wake_evt = i_periph_irq | (|pin_hit);
      power_mode_pkg::ST_SHUT: wake_evt = i_timer_wake | (|pin_hit);
      default: wake_evt = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next-state logic for registers and sequencer.
  // ==========================================================================
  always_comb begin
    next_sel = sel;
    next_wake_en = wake_en;
    next_flash_off = flash_off;
    next_flag_mode2 = flag_mode2;
    next_flag_shut = flag_shut;
    next_pull_a = pull_a;
    next_pull_c = pull_c;
    next_pull_d = pull_d;
    next_pull_e = pull_e;
    next_wr_pend = addr_phase & i_hwrite;
    next_wr_addr = addr_phase ? ofs : wr_addr;
    next_rdata = (addr_phase & ~i_hwrite) ? rd_mux : 32'h0;
    next_state = state;
    next_wake_from = wake_from;
    next_cnt = cnt;

    // Data-phase writes.
    if (wr_pend) begin
      case (wr_addr)
        power_mode_pkg::OFS_CONTROL: begin
          // Writes without the key are dropped whole.
          if (i_hwdata[power_mode_pkg::KEY_LSB +: 16] == power_mode_pkg::UNLOCK_KEY) begin
            next_sel = i_hwdata[power_mode_pkg::SEL_LSB +: 2];
            next_wake_en = i_hwdata[power_mode_pkg::WAKE_EN_LSB +: WAKE_PINS];
            next_flash_off = i_hwdata[power_mode_pkg::FLASH_OFF_BIT];
          end
        end
        power_mode_pkg::OFS_STATUS: begin
          // Write one to clear.
          if (i_hwdata[power_mode_pkg::ST_MODE2_BIT]) next_flag_mode2 = 1'b0;
          if (i_hwdata[power_mode_pkg::ST_SHUT_BIT]) next_flag_shut = 1'b0;
        end
        power_mode_pkg::OFS_PULL_A: next_pull_a = i_hwdata & power_mode_pkg::MASK_PULL_A;
        power_mode_pkg::OFS_PULL_C: next_pull_c = i_hwdata & power_mode_pkg::MASK_PULL_C;
        power_mode_pkg::OFS_PULL_D: next_pull_d = i_hwdata & power_mode_pkg::MASK_PULL_D;
        power_mode_pkg::OFS_PULL_E: next_pull_e = i_hwdata & power_mode_pkg::MASK_PULL_E;
        default: ;
      endcase
    end

    // Power sequencer.
    case (state)
      power_mode_pkg::ST_RUN: begin
        // Enter sleep only on request with a valid code.
        if (i_sleep_req && sel != power_mode_pkg::SEL_UNUSED) begin
          case (sel)
            power_mode_pkg::SEL_MODE0: next_state = power_mode_pkg::ST_SLEEP0;
            power_mode_pkg::SEL_MODE2: next_state = power_mode_pkg::ST_SLEEP2;
            default: next_state = power_mode_pkg::ST_SHUT;
          endcase
        end
      end
      power_mode_pkg::ST_SLEEP0, power_mode_pkg::ST_SLEEP2, power_mode_pkg::ST_SHUT: begin
        if (wake_evt) begin
          next_sel = power_mode_pkg::SEL_MODE0;
          next_wake_from = state;
          next_state = power_mode_pkg::ST_WAKE;
          next_cnt = 32'h0;
        end
      end
      power_mode_pkg::ST_WAKE: begin
        // Stay within the worst-case wake delays.
        next_cnt = cnt + 32'h1;
        if (wake_from == power_mode_pkg::ST_SLEEP0) begin
          if (cnt + 32'h1 >= 32'(power_mode_pkg::MODE0_WAKE_CYC)) begin
            next_state = power_mode_pkg::ST_RUN;
          end
        end else if (wake_from == power_mode_pkg::ST_SLEEP2) begin
          if (cnt + 32'h1 >= 32'(power_mode_pkg::MODE2_WAKE_CYC - power_mode_pkg::RESET_PULSE_CYC)) begin
            next_state = power_mode_pkg::ST_RSTOUT;
            next_cnt = 32'h0;
          end
        end else if (cnt + 32'h1 >= 32'(SHUT_WAKE_CYCLES - power_mode_pkg::RESET_PULSE_CYC)) begin
          next_state = power_mode_pkg::ST_RSTOUT;
          next_cnt = 32'h0;
        end
      end
      power_mode_pkg::ST_RSTOUT: begin
        next_cnt = cnt + 32'h1;
        if (cnt + 32'h1 >= 32'(power_mode_pkg::RESET_PULSE_CYC)) begin
          next_state = power_mode_pkg::ST_RUN;
          if (wake_from == power_mode_pkg::ST_SHUT) begin
            // System reset acts like power-on for the control state.
            next_flag_shut = 1'b1;
            next_wake_en = '0;
            next_flash_off = 1'b0;
            next_pull_a = 32'h0;
            next_pull_c = 32'h0;
            next_pull_d = 32'h0;
            next_pull_e = 32'h0;
          end else begin
            next_flag_mode2 = 1'b1;
          end
        end
      end
      default: next_state = power_mode_pkg::ST_RUN;
    endcase
  end

  // ==========================================================================
  // Register updates; power-on reset and write-one-to-clear clear the flags, a system reset does not.
  // ==========================================================================
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sel <= power_mode_pkg::SEL_MODE0;
      wake_en <= '0;
      flash_off <= 1'b0;
      flag_mode2 <= 1'b0;
      flag_shut <= 1'b0;
      pull_a <= 32'h0;
      pull_c <= 32'h0;
      pull_d <= 32'h0;
      pull_e <= 32'h0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
      state <= power_mode_pkg::ST_RUN;
      wake_from <= power_mode_pkg::ST_RUN;
      cnt <= 32'h0;
    end else begin
      sel <= next_sel;
      wake_en <= next_wake_en;
      flash_off <= next_flash_off;
      flag_mode2 <= next_flag_mode2;
      flag_shut <= next_flag_shut;
      pull_a <= next_pull_a;
      pull_c <= next_pull_c;
      pull_d <= next_pull_d;
      pull_e <= next_pull_e;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      state <= next_state;
      wake_from <= next_wake_from;
      cnt <= next_cnt;
    end
  end

  // Backup bytes have no reset and so survive every reset.
  for (genvar b = 0; b < power_mode_pkg::BACKUP_BYTES; b++) begin : g_backup
    logic hit;
    assign hit = wr_pend && (wr_addr >= power_mode_pkg::OFS_BACKUP_LO) &&
                 (wr_addr <= power_mode_pkg::OFS_BACKUP_HI) &&
                 (wr_addr[4:2] == 3'(b / 4));
    always_ff @(posedge i_ref_clk) begin
      if (hit) begin
        backup[b] <= i_hwdata[8 * (b % 4) +: 8];
      end
    end
  end

  // ==========================================================================
  // Registered outputs.
  // ==========================================================================
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_hrdata <= 32'h0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_flash_power_off <= 1'b0;
      o_core_asleep <= 1'b0;
      o_cpu_reset <= 1'b0;
      o_sys_reset <= 1'b0;
      o_shutdown <= 1'b0;
      o_pull_a <= 16'h0;
      o_pull_c <= 16'h0;
      o_pull_d <= 16'h0;
      o_pull_e <= 16'h0;
    end else begin
      o_hrdata <= next_rdata;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_flash_power_off <= next_flash_off;
      o_core_asleep <= (next_state != power_mode_pkg::ST_RUN);
      o_cpu_reset <= (next_state == power_mode_pkg::ST_RSTOUT) &&
                     (next_wake_from == power_mode_pkg::ST_SLEEP2);
      o_sys_reset <= (next_state == power_mode_pkg::ST_RSTOUT) &&
                     (next_wake_from == power_mode_pkg::ST_SHUT);
      o_shutdown <= next_shut;
      // Pulls apply only in shutdown.
      o_pull_a <= next_shut ? next_pull_a[15:0] : 16'h0;
      o_pull_c <= next_shut ? next_pull_c[15:0] : 16'h0;
      o_pull_d <= next_shut ? next_pull_d[15:0] : 16'h0;
      o_pull_e <= next_shut ? next_pull_e[15:0] : 16'h0;
    end
  end

endmodule // power_mode_controller

/* rtl/power_mode_pkg.sv */
// Constants, register map and power states for the power mode controller.
package power_mode_pkg;

  // ==========================================================================
  // Register offsets (byte addresses).
  // ==========================================================================
  localparam logic [7:0] OFS_CONTROL = 8'h00; // Power control register.
  localparam logic [7:0] OFS_STATUS = 8'h08; // Wake reset status register.
  localparam logic [7:0] OFS_PULL_A = 8'h10; // Port A shutdown pulls.
  localparam logic [7:0] OFS_PULL_C = 8'h18; // Port C shutdown pulls.
  localparam logic [7:0] OFS_PULL_D = 8'h1C; // Port D shutdown pulls.
  localparam logic [7:0] OFS_PULL_E = 8'h20; // Port E shutdown pulls.
  localparam logic [7:0] OFS_BACKUP_LO = 8'h40; // First backup word.
  localparam logic [7:0] OFS_BACKUP_HI = 8'h5F; // Last backup byte.

  // ==========================================================================
  // Control register fields.
  // ==========================================================================
  localparam logic [15:0] UNLOCK_KEY = 16'h5A3C; // Value of write_unlock_key.
  localparam int KEY_LSB = 16; // Lowest key bit.
  localparam int SEL_LSB = 14; // Lowest bit of low_power_select.
  localparam int WAKE_EN_LSB = 9; // wake_pin_enable[0] position.
  localparam int FLASH_OFF_BIT = 8; // flash_power_off position.
  localparam int WAKE_PINS = 2; // Number of wake-up pins.

  // Low-power selection codes.
  localparam logic [1:0] SEL_MODE0 = 2'h0; // Deep sleep mode 0.
  localparam logic [1:0] SEL_UNUSED = 2'h1; // Not used.
  localparam logic [1:0] SEL_MODE2 = 2'h2; // Deep sleep mode 2.
  localparam logic [1:0] SEL_SHUTDOWN = 2'h3; // Shutdown.

  // ==========================================================================
  // Status register fields.
  // ==========================================================================
  localparam int ST_MODE2_BIT = 2; // mode2_wake_reset_flag.
  localparam int ST_SHUT_BIT = 3; // shutdown_wake_reset_flag.

  // ==========================================================================
  // Pull register valid-bit masks.
  // ==========================================================================
  localparam logic [31:0] MASK_PULL_A = 32'h0000FFFF; // Pins 0 to 7.
  localparam logic [31:0] MASK_PULL_C = 32'h00003C00; // Pins 5 and 6.
  localparam logic [31:0] MASK_PULL_D = 32'h00000FC0; // Pins 3 to 5.
  localparam logic [31:0] MASK_PULL_E = 32'h000000FF; // Pins 0 to 3.
  localparam int BACKUP_BYTES = 32; // Number of backup bytes.

  // ==========================================================================
  // Timing.
  // ==========================================================================
  localparam int CLK_HZ = 25_000_000; // Reference clock rate.
  localparam int MODE0_WAKE_NS = 8000; // Longest mode 0 resume time.
  localparam int MODE2_WAKE_NS = 8000; // Longest mode 2 reset delay.
  localparam int SHUT_WAKE_US = 9800; // Longest shutdown reset delay.
  // Longest times round down to whole cycles.
  localparam int MODE0_WAKE_CYC = MODE0_WAKE_NS / (1_000_000_000 / CLK_HZ);
  localparam int MODE2_WAKE_CYC = MODE2_WAKE_NS / (1_000_000_000 / CLK_HZ);
  localparam int SHUT_WAKE_CYC = SHUT_WAKE_US * (CLK_HZ / 1_000_000);
  localparam int RESET_PULSE_CYC = 4; // Length of a reset pulse.

  // Power states.
  typedef enum logic [5:0] {
    ST_RUN = 6'b000001,
    ST_SLEEP0 = 6'b000010,
    ST_SLEEP2 = 6'b000100,
    ST_SHUT = 6'b001000,
    ST_WAKE = 6'b010000,
    ST_RSTOUT = 6'b100000
  } power_state_e;

endpackage
